// *** core/residual_overvoltage_stage.sv ***
// residual overvoltage pick-up stage with register port and interrupt
`timescale 1ns/1ns
`default_nettype none
module residual_overvoltage_stage (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // magnitudes from the measurement chain
    input  wire logic                        meas_valid,
    input  wire logic [nov_pkg::MAG_W-1:0]   mag_l1,
    input  wire logic [nov_pkg::MAG_W-1:0]   mag_l2,
    input  wire logic [nov_pkg::MAG_W-1:0]   mag_l3,
    input  wire logic [nov_pkg::MAG_W-1:0]   mag_ch3,
    input  wire logic [nov_pkg::MAG_W-1:0]   mag_ch4,
    input  wire logic                        ch3_residual_mode,
    input  wire logic                        ch4_residual_mode,
    input  wire logic                        phase_to_neutral,
    // global enables and block
    input  wire logic                        node_mode_enable,
    input  wire logic                        forcing_enable,
    input  wire logic                        block_in,
    // register port
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output var  logic [31:0]                 reg_rdata,
    // outputs
    output var  logic                        start_out,
    output var  logic                        trip_out,
    output var  logic                        blocked_out,
    output var  logic                        irq
);
    localparam logic [31:0] STEP_CYC_W = 32'(nov_pkg::STEP_CYC);
    localparam logic [31:0] HNUM = 32'(nov_pkg::HYST_NUM);
    localparam logic [31:0] HDEN = 32'(nov_pkg::HYST_DEN);
    localparam logic [31:0] FULLP = 32'(nov_pkg::FULL_PCT);
    localparam logic [31:0] NOMCV = 32'(nov_pkg::NOM_RES_CV);

    // static settings and register state
    logic [2:0]  mode_ff, nxt_mode;
    logic [1:0]  force_ff, nxt_force;
    logic [1:0]  src_ff, nxt_src;
    logic [nov_pkg::GRP_W-1:0] grp_ff, nxt_grp;
    logic [nov_pkg::GRP_W-1:0] edit_ff, nxt_edit;
    logic [nov_pkg::IRQ_W-1:0] ist_ff, nxt_ist, imsk_ff, nxt_imsk;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        irq_ff, nxt_irq;
    logic [31:0] grp_rd;
    logic        grp_wr;

    // datapath state
    logic        pick_ff, nxt_pick;
    logic [31:0] pct_ff, nxt_pct;
    logic [15:0] ratio_ff, nxt_ratio;
    logic [1:0]  stage_ff, nxt_stage;
    logic [31:0] cyc_ff, nxt_cyc;
    logic [17:0] steps_ff, nxt_steps;
    logic        start_ff, trip_ff, blk_ff;
    logic        nxt_start_o, nxt_trip_o, nxt_blk_o;

    // threshold and delay of active group
    logic [nov_pkg::PCT_W-1:0] thr;
    logic [17:0]               dly;
    assign thr = grp_rd[nov_pkg::PCT_W-1:0];
    assign dly = grp_rd[31:14];

    // register select decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    // group writes land in the group named by the edit pointer
    assign grp_wr = reg_wr && (hit(reg_addr, nov_pkg::OFF_PICKUP) ||
                               hit(reg_addr, nov_pkg::OFF_DELAY));

    // pending group write: merged with the edit group's word next cycle
    logic        pend_ff, nxt_pend;
    logic        pend_pick_ff, nxt_pend_pick;
    logic [17:0] pend_data_ff, nxt_pend_data;
    assign nxt_pend = grp_wr;
    assign nxt_pend_pick = hit(reg_addr, nov_pkg::OFF_PICKUP);
    assign nxt_pend_data = reg_wdata[17:0];

    // pending write registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pend_ff <= 1'b0;
            pend_pick_ff <= 1'b0;
            pend_data_ff <= 18'h00000;
        end
        else
        begin
            pend_ff <= nxt_pend;
            pend_pick_ff <= nxt_pend_pick;
            pend_data_ff <= nxt_pend_data;
        end
    end

    group_mem u_mem (
        .clk     (clk),
        .wr_en   (pend_ff),
        .wr_grp  (edit_ff),
        .wr_data (pend_pick_ff
                  ? {grp_rd[31:14], pend_data_ff[13:0]}
                  : {pend_data_ff, grp_rd[13:0]}),
        .rd_grp  (grp_wr ? edit_ff : grp_ff),
        .rd_data (grp_rd)
    );

    // source selection and scaling
    // rms magnitudes only
    logic [31:0] raw, scaled, pct_now;
    logic        src_ok;
    always_comb
    begin
        raw = 32'h0000_0000;
        src_ok = 1'b1;
        case (nov_pkg::source_t'(src_ff))
            nov_pkg::SRC_CH3:
                if (ch3_residual_mode) raw = {16'h0000, mag_ch3};
                else src_ok = 1'b0;
            nov_pkg::SRC_CH4:
                if (ch4_residual_mode) raw = {16'h0000, mag_ch4};
                else src_ok = 1'b0;
            nov_pkg::SRC_CALC,
            nov_pkg::SRC_SELECT:
                if (phase_to_neutral)
                    raw = ({16'h0000, mag_l1} + {16'h0000, mag_l2}
                           + {16'h0000, mag_l3}) / 32'h0000_0003;
                else src_ok = 1'b0;
            default: src_ok = 1'b0;
        endcase
        scaled = raw * FULLP / NOMCV;
        pct_now = src_ok ? scaled : 32'h0000_0000;
    end

    // pick-up, ratio and stage sequence
    logic off_m, blk_m;
    always_comb
    begin
        nxt_pick = pick_ff;
        nxt_pct = pct_ff;
        nxt_ratio = ratio_ff;
        nxt_stage = stage_ff;
        nxt_cyc = cyc_ff;
        nxt_steps = steps_ff;
        off_m = (mode_ff == 3'(nov_pkg::MODE_OFF)) && node_mode_enable;
        blk_m = node_mode_enable && (mode_ff == 3'(nov_pkg::MODE_BLOCKED)
                || mode_ff == 3'(nov_pkg::MODE_TEST_BLK));
        if (meas_valid)
        begin
            nxt_pct = pct_now;
            nxt_ratio = (thr == 14'h0000) ? 16'hFFFF
                        : 16'((pct_now * 32'h0000_0064) / {18'h0, thr});
            if (!pick_ff && pct_now > {18'h0, thr})
                nxt_pick = 1'b1;
            else if (pick_ff && pct_now * HDEN < {18'h0, thr} * HNUM)
                nxt_pick = 1'b0;
        end
        if (off_m)
            nxt_pick = 1'b0;
        // stage sequence
        case (nov_pkg::stage_t'(stage_ff))
            nov_pkg::ST_IDLE:
                if (nxt_pick && !pick_ff)
                begin
                    nxt_cyc = 32'h0000_0000;
                    nxt_steps = 18'h00000;
                    if (block_in || blk_m)
                        nxt_stage = 2'(nov_pkg::ST_BLOCKED);
                    else if (dly == 18'h00000)
                        nxt_stage = 2'(nov_pkg::ST_TRIP);
                    else
                        nxt_stage = 2'(nov_pkg::ST_START);
                end
            nov_pkg::ST_START:
                if (!nxt_pick || block_in || blk_m)
                    nxt_stage = 2'(nov_pkg::ST_IDLE);
                else if (cyc_ff == STEP_CYC_W - 32'h0000_0001)
                begin
                    nxt_cyc = 32'h0000_0000;
                    nxt_steps = steps_ff + 18'h00001;
                    if (steps_ff + 18'h00001 >= dly)
                        nxt_stage = 2'(nov_pkg::ST_TRIP);
                end
                else
                    nxt_cyc = cyc_ff + 32'h0000_0001;
            nov_pkg::ST_TRIP,
            nov_pkg::ST_BLOCKED:
                if (!nxt_pick)
                    nxt_stage = 2'(nov_pkg::ST_IDLE);
            default: nxt_stage = 2'(nov_pkg::ST_IDLE);
        endcase
        nxt_start_o = nxt_stage == 2'(nov_pkg::ST_START)
                      || nxt_stage == 2'(nov_pkg::ST_TRIP);
        nxt_trip_o = nxt_stage == 2'(nov_pkg::ST_TRIP);
        nxt_blk_o = nxt_stage == 2'(nov_pkg::ST_BLOCKED);
        if (forcing_enable && force_ff != 2'(nov_pkg::FORCE_NORMAL))
        begin
            nxt_start_o = force_ff != 2'(nov_pkg::FORCE_BLOCKED);
            nxt_trip_o = force_ff == 2'(nov_pkg::FORCE_TRIP);
            nxt_blk_o = force_ff == 2'(nov_pkg::FORCE_BLOCKED);
        end
    end

    // register port, interrupt status and mask
    logic [nov_pkg::IRQ_W-1:0] ev;
    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_force = force_ff;
        nxt_src = src_ff;
        nxt_grp = grp_ff;
        nxt_edit = edit_ff;
        nxt_imsk = imsk_ff;
        nxt_rdata = 32'h0000_0000;
        ev = {nxt_blk_o & ~blk_ff, nxt_trip_o & ~trip_ff,
              nxt_start_o & ~start_ff};
        nxt_ist = ist_ff;
        if (reg_wr)
        begin
            if (hit(reg_addr, nov_pkg::OFF_CTRL))
            begin
                if (node_mode_enable && reg_wdata[2:0] <= 3'h4)
                    nxt_mode = reg_wdata[2:0];
                if (forcing_enable)
                    nxt_force = reg_wdata[5:4];
                nxt_src = reg_wdata[9:8];
            end
            if (hit(reg_addr, nov_pkg::OFF_GROUP))
            begin
                nxt_grp = reg_wdata[2:0];
                nxt_edit = reg_wdata[10:8];
            end
            if (hit(reg_addr, nov_pkg::OFF_IRQ_ST))
                nxt_ist = ist_ff & ~reg_wdata[2:0];
            if (hit(reg_addr, nov_pkg::OFF_IRQ_MSK))
                nxt_imsk = reg_wdata[2:0];
        end
        // set wins over clear
        nxt_ist = nxt_ist | ev;
        if (reg_rd)
        begin
            case (reg_addr)
                nov_pkg::OFF_CTRL:
                    nxt_rdata = {22'h0, src_ff, 2'h0, force_ff, 1'b0, mode_ff};
                nov_pkg::OFF_PICKUP: nxt_rdata = {18'h0, thr};
                nov_pkg::OFF_DELAY:  nxt_rdata = {14'h0, dly};
                nov_pkg::OFF_GROUP:  nxt_rdata = {21'h0, edit_ff, 5'h0, grp_ff};
                nov_pkg::OFF_STATUS:
                    nxt_rdata = {28'h0, pick_ff, blk_ff, trip_ff, start_ff};
                nov_pkg::OFF_RATIO:  nxt_rdata = {16'h0, ratio_ff};
                nov_pkg::OFF_IRQ_ST: nxt_rdata = {29'h0, ist_ff};
                nov_pkg::OFF_IRQ_MSK: nxt_rdata = {29'h0, imsk_ff};
                nov_pkg::OFF_MAG:    nxt_rdata = pct_ff;
                default:             nxt_rdata = 32'h0000_0000;
            endcase
        end
        nxt_irq = |(nxt_ist & nxt_imsk);
    end

    // state registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_ff <= 3'(nov_pkg::MODE_ON);
            force_ff <= 2'(nov_pkg::FORCE_NORMAL);
            src_ff <= 2'(nov_pkg::SRC_SELECT);
            grp_ff <= '0;
            edit_ff <= '0;
            ist_ff <= '0;
            imsk_ff <= '0;
            rdata_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            pick_ff <= 1'b0;
            pct_ff <= 32'h0000_0000;
            ratio_ff <= 16'h0000;
            stage_ff <= 2'(nov_pkg::ST_IDLE);
            cyc_ff <= 32'h0000_0000;
            steps_ff <= 18'h00000;
            start_ff <= 1'b0;
            trip_ff <= 1'b0;
            blk_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            force_ff <= nxt_force;
            src_ff <= nxt_src;
            grp_ff <= nxt_grp;
            edit_ff <= nxt_edit;
            ist_ff <= nxt_ist;
            imsk_ff <= nxt_imsk;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            pick_ff <= nxt_pick;
            pct_ff <= nxt_pct;
            ratio_ff <= nxt_ratio;
            stage_ff <= nxt_stage;
            cyc_ff <= nxt_cyc;
            steps_ff <= nxt_steps;
            start_ff <= nxt_start_o;
            trip_ff <= nxt_trip_o;
            blk_ff <= nxt_blk_o;
        end
    end

    assign reg_rdata = rdata_ff;
    assign start_out = start_ff;
    assign trip_out = trip_ff;
    assign blocked_out = blk_ff;
    assign irq = irq_ff;

    // checks
    AST_TRIP_HAS_START: assert property (@(posedge clk) disable iff (!rst_n)
        trip_out && !forcing_enable |-> start_out)
        else $error("trip without start");
    AST_BLOCK_EXCL: assert property (@(posedge clk) disable iff (!rst_n)
        blocked_out && !forcing_enable |-> !start_out)
        else $error("blocked with start");
    AST_HOLD_NO_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
        !meas_valid && !off_m |=> pick_ff == $past(pick_ff))
        else $error("pick-up moved without strobe");
    AST_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        meas_valid && !off_m && pct_now > {18'h0, thr} |=> pick_ff)
        else $error("no pick-up above threshold");
    AST_HYST: assert property (@(posedge clk) disable iff (!rst_n)
        meas_valid && !off_m && pick_ff && pct_now * HDEN >= {18'h0, thr} * HNUM
        |=> pick_ff)
        else $error("released inside hysteresis");
    AST_MODE_STATIC: assert property (@(posedge clk) disable iff (!rst_n)
        !(reg_wr && hit(reg_addr, nov_pkg::OFF_CTRL)) |=> $stable(mode_ff))
        else $error("mode changed without write");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        |(ist_ff & imsk_ff) |-> irq)
        else $error("irq missing");
    AST_MODE_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff <= 3'h4)
        else $error("illegal mode");
    COV_TRIP: cover property (@(posedge clk) trip_out);
    COV_BLOCK: cover property (@(posedge clk) blocked_out);
    COV_RELEASE: cover property (@(posedge clk) $fell(pick_ff));
endmodule : residual_overvoltage_stage
`default_nettype wire

// *** core/nov_pkg.sv ***
// constants and types shared by the residual overvoltage pick-up stage
package nov_pkg;

    // magnitude and setting widths
    localparam int MAG_W = 16;                  // rms magnitude, 0.01 V lsb
    localparam int PCT_W = 14;                  // percent of nominal, 0.01 %
    localparam int RATIO_W = 16;                // ratio, 0.01 lsb

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_PICKUP  = 8'h04;
    localparam logic [7:0] OFF_DELAY   = 8'h08;
    localparam logic [7:0] OFF_GROUP   = 8'h0C;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_RATIO   = 8'h14;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h1C;
    localparam logic [7:0] OFF_MAG     = 8'h20;

    // setting groups
    localparam int NUM_GROUPS = 8;
    localparam int GRP_W = 3;

    // control field positions
    localparam int CTRL_MODE_LSB  = 0;          // 3 bits
    localparam int CTRL_FORCE_LSB = 4;          // 2 bits
    localparam int CTRL_SRC_LSB   = 8;          // 2 bits

    // reset values
    localparam logic [PCT_W-1:0] PICKUP_RST = 14'h07D0;   // 20.00 %
    localparam logic [17:0] DELAY_RST = 18'h00008;        // 0.040 s in steps

    // hysteresis: release below 97/100 of threshold
    localparam int HYST_NUM = 97;
    localparam int HYST_DEN = 100;

    // nominal scaling: 57.74 V residual equals 100 % (10000 counts)
    localparam int NOM_RES_CV = 5774;           // centivolts
    localparam int FULL_PCT   = 10000;

    // delay step 0.005 s in cycles of 8 ns
    localparam int CLK_NS = 8;
    localparam int STEP_NS = 5000000;
    localparam int STEP_CYC = STEP_NS / CLK_NS;

    // interrupt bits
    localparam int IRQ_START = 0;
    localparam int IRQ_TRIP  = 1;
    localparam int IRQ_BLOCK = 2;
    localparam int IRQ_W = 3;

    typedef enum logic [2:0] {
        MODE_ON       = 3'b000,
        MODE_BLOCKED  = 3'b001,
        MODE_TEST     = 3'b010,
        MODE_TEST_BLK = 3'b011,
        MODE_OFF      = 3'b100
    } node_operating_mode_t;

    typedef enum logic [1:0] {
        FORCE_NORMAL  = 2'b00,
        FORCE_START   = 2'b01,
        FORCE_TRIP    = 2'b10,
        FORCE_BLOCKED = 2'b11
    } force_t;

    typedef enum logic [1:0] {
        SRC_SELECT = 2'b00,
        SRC_CALC   = 2'b01,
        SRC_CH3    = 2'b10,
        SRC_CH4    = 2'b11
    } source_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_START   = 2'b01,
        ST_TRIP    = 2'b10,
        ST_BLOCKED = 2'b11
    } stage_t;

endpackage : nov_pkg

// *** core/group_mem.sv ***
// setting-group memory: threshold and delay per group, registered read
`timescale 1ns/1ns
`default_nettype none
module group_mem (
    // clock
    input  wire logic                       clk,
    // write port
    input  wire logic                       wr_en,
    input  wire logic [nov_pkg::GRP_W-1:0]  wr_grp,
    input  wire logic [31:0]                wr_data,
    // read port
    input  wire logic [nov_pkg::GRP_W-1:0]  rd_grp,
    output var  logic [31:0]                rd_data
);
    logic [31:0] mem [nov_pkg::NUM_GROUPS];

    // storage and registered read
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_grp] <= wr_data;
        end
        rd_data <= mem[rd_grp];
    end
endmodule : group_mem
`default_nettype wire

// *** bench/meas_chain_model.sv ***
// measurement chain model: rms magnitudes once per program cycle
`timescale 1ns/1ns
`default_nettype none
module meas_chain_model #(
    parameter int PERIOD = 16
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // magnitudes toward the stage
    output var  logic                      meas_valid,
    output var  logic [nov_pkg::MAG_W-1:0] mag_l1,
    output var  logic [nov_pkg::MAG_W-1:0] mag_l2,
    output var  logic [nov_pkg::MAG_W-1:0] mag_l3,
    output var  logic [nov_pkg::MAG_W-1:0] mag_ch3,
    output var  logic [nov_pkg::MAG_W-1:0] mag_ch4
);
    logic [nov_pkg::MAG_W-1:0] held [5] = '{default: '0};
    int                        cnt = 0;
    logic                      fire;

    initial meas_valid = 1'b0;

    // staged values, taken at the next program cycle
    task automatic set_mags(input logic [15:0] a, b, c, d, e);
        held <= '{a, b, c, d, e};
    endtask : set_mags

    assign fire = rst_n && cnt == PERIOD - 1;

    always @(posedge clk)
    begin
        cnt <= fire || !rst_n ? 0 : cnt + 1;
        meas_valid <= fire;
    end

    // fundamental rms values; stale lines are inverted
    always @(posedge clk)
    begin
        mag_l1 <= fire ? held[0] : ~held[0];
        mag_l2 <= fire ? held[1] : ~held[1];
        mag_l3 <= fire ? held[2] : ~held[2];
        mag_ch3 <= fire ? held[3] : ~held[3];
        mag_ch4 <= fire ? held[4] : ~held[4];
    end
endmodule : meas_chain_model
`default_nettype wire

// *** bench/tb_residual_overvoltage_stage.sv ***
// self-checking bench for the residual overvoltage pick-up stage
`timescale 1ns/1ns
`default_nettype none
module tb_residual_overvoltage_stage;
    localparam int PER = 16;
    logic                      clk = 1'b0;
    logic                      rst_n = 1'b0;
    logic                      meas_valid;
    logic [nov_pkg::MAG_W-1:0] mag_l1, mag_l2, mag_l3, mag_ch3, mag_ch4;
    logic                      ch3_residual_mode = 1'b1;
    logic                      ch4_residual_mode = 1'b1;
    logic                      phase_to_neutral = 1'b1;
    logic                      node_mode_enable = 1'b1;
    logic                      forcing_enable = 1'b1;
    logic                      block_in = 1'b0;
    logic [7:0]                reg_addr = 8'h00;
    logic [31:0]               reg_wdata = 32'h0;
    logic                      reg_wr = 1'b0;
    logic                      reg_rd = 1'b0;
    logic [31:0]               reg_rdata;
    logic                      start_out, trip_out, blocked_out, irq;
    logic [31:0]               src_exp [4] = '{32'h2710, 32'h2710,
                                               32'h1388, 32'h3A98};
    logic [31:0]               fmask [4] = '{32'h0, 32'h1, 32'h3, 32'h4};
    logic [31:0]               outs;
    int                        err_total = 0;
    int                        comparisons = 0;
    int                        cycles = 0;
    int                        i;

    meas_chain_model #(.PERIOD(PER)) chain (
        .clk(clk), .rst_n(rst_n), .meas_valid(meas_valid),
        .mag_l1(mag_l1), .mag_l2(mag_l2), .mag_l3(mag_l3),
        .mag_ch3(mag_ch3), .mag_ch4(mag_ch4)
    );

    residual_overvoltage_stage uut (
        .clk(clk), .rst_n(rst_n), .meas_valid(meas_valid),
        .mag_l1(mag_l1), .mag_l2(mag_l2), .mag_l3(mag_l3),
        .mag_ch3(mag_ch3), .mag_ch4(mag_ch4),
        .ch3_residual_mode(ch3_residual_mode),
        .ch4_residual_mode(ch4_residual_mode),
        .phase_to_neutral(phase_to_neutral),
        .node_mode_enable(node_mode_enable),
        .forcing_enable(forcing_enable), .block_in(block_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_out(start_out),
        .trip_out(trip_out), .blocked_out(blocked_out), .irq(irq)
    );

    assign outs = {29'h0, blocked_out, trip_out, start_out};

    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write, then an idle cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    // one-cycle read, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // new third-channel value, wait two program cycles and four clocks
    task automatic ch3v(input logic [15:0] v);
        chain.set_mags(16'h168E, 16'h168E, 16'h168E, v, 16'h21D5);
        repeat (2 * PER + 4) @(posedge clk);
        #1;
    endtask : ch3v

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(nov_pkg::OFF_CTRL, 32'h0);
        rd(8'h40, 32'h0);
        wr(nov_pkg::OFF_GROUP, 32'h100);
        wr(nov_pkg::OFF_PICKUP, 32'h1F40);
        wr(nov_pkg::OFF_DELAY, 32'h0);
        wr(nov_pkg::OFF_GROUP, 32'h0);
        wr(nov_pkg::OFF_PICKUP, 32'h1388);
        wr(nov_pkg::OFF_DELAY, 32'h0);
        rd(nov_pkg::OFF_PICKUP, 32'h1388);
        for (i = 0; i < 4; i++)
        begin
            wr(nov_pkg::OFF_CTRL, 32'(i) << 8);
            ch3v(16'h0B47);
            rd(nov_pkg::OFF_MAG, src_exp[i]);
        end
        rd(nov_pkg::OFF_RATIO, 32'h12C);
        @(posedge clk) ch3_residual_mode <= 1'b0;
        wr(nov_pkg::OFF_CTRL, 32'h200);
        ch3v(16'h0B47);
        rd(nov_pkg::OFF_MAG, 32'h0);
        @(posedge clk) ch3_residual_mode <= 1'b1;
        @(posedge clk) phase_to_neutral <= 1'b0;
        wr(nov_pkg::OFF_CTRL, 32'h100);
        ch3v(16'h0B47);
        rd(nov_pkg::OFF_MAG, 32'h0);
        @(posedge clk) phase_to_neutral <= 1'b1;
        wr(nov_pkg::OFF_CTRL, 32'h200);
        ch3v(16'h0B47);
        chk(outs, 32'h0);
        wr(nov_pkg::OFF_IRQ_ST, 32'h7);
        ch3v(16'h0B48);
        chk(outs, 32'h3);
        rd(nov_pkg::OFF_IRQ_ST, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(nov_pkg::OFF_IRQ_MSK, 32'h7);
        chk({31'h0, irq}, 32'h1);
        wr(nov_pkg::OFF_IRQ_ST, 32'h3);
        rd(nov_pkg::OFF_IRQ_ST, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(nov_pkg::OFF_IRQ_MSK, 32'h0);
        ch3v(16'h0AF2);
        chk(outs, 32'h3);
        ch3v(16'h0AF0);
        chk(outs, 32'h0);
        ch3v(16'h0D89);
        chk(outs, 32'h3);
        wr(nov_pkg::OFF_GROUP, 32'h1);
        ch3v(16'h0D89);
        chk(outs, 32'h0);
        rd(nov_pkg::OFF_CTRL, 32'h200);
        wr(nov_pkg::OFF_DELAY, 32'h1);
        wr(nov_pkg::OFF_GROUP, 32'h0);
        ch3v(16'h0D89);
        chk(outs, 32'h1);
        ch3v(16'h0AF0);
        wr(nov_pkg::OFF_IRQ_ST, 32'h7);
        @(posedge clk) block_in <= 1'b1;
        ch3v(16'h0D89);
        chk(outs, 32'h4);
        rd(nov_pkg::OFF_IRQ_ST, 32'h4);
        @(posedge clk) block_in <= 1'b0;
        ch3v(16'h0AF0);
        @(posedge clk) node_mode_enable <= 1'b0;
        wr(nov_pkg::OFF_CTRL, 32'h201);
        rd(nov_pkg::OFF_CTRL, 32'h200);
        @(posedge clk) node_mode_enable <= 1'b1;
        for (i = 0; i < 5; i++)
        begin
            wr(nov_pkg::OFF_CTRL, 32'h200 | 32'(i));
            rd(nov_pkg::OFF_CTRL, 32'h200 | 32'(i));
        end
        wr(nov_pkg::OFF_CTRL, 32'h205);
        rd(nov_pkg::OFF_CTRL, 32'h204);
        ch3v(16'h0D89);
        chk(outs, 32'h0);
        wr(nov_pkg::OFF_CTRL, 32'h201);
        ch3v(16'h0D89);
        chk(outs, 32'h4);
        ch3v(16'h0AF0);
        @(posedge clk) forcing_enable <= 1'b0;
        wr(nov_pkg::OFF_CTRL, 32'h210);
        rd(nov_pkg::OFF_CTRL, 32'h200);
        @(posedge clk) forcing_enable <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            wr(nov_pkg::OFF_CTRL, 32'h200 | (32'(i) << 4));
            ch3v(16'h0AF0);
            chk(outs, fmask[i]);
        end
        give_verdict();
    end
endmodule : tb_residual_overvoltage_stage
`default_nettype wire
